// ### src/flash_host.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [7:0]        S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [7:0]        S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  output logic                   FLASH_RESET_N_O,
  output logic                   FLASH_RESET_ELEV_O,
  output logic                   FLASH_CE_N_O,
  output logic                   FLASH_OE_N_O,
  output logic                   FLASH_WE_N_O,
  output logic                   FLASH_WIDTH_SELECT_O,
  output logic [ADDR_W-1:0]      FLASH_ADDR_O,
  input  wire logic [DATA_W-1:0] FLASH_DQ_I,
  output logic [DATA_W-1:0]      FLASH_DQ_O,
  output logic                   FLASH_DQ_OE_O,
  input  wire logic              FLASH_READY_BUSY_N_I
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
  logic              rb_s1_reg, rb_s2_reg;
  always_ff @(posedge SYS_CLK_I) begin
    dq_s1_reg <= FLASH_DQ_I;
    dq_s2_reg <= dq_s1_reg;
    rb_s1_reg <= FLASH_READY_BUSY_N_I;
    rb_s2_reg <= rb_s1_reg;
  end

  // ----------------------------------------
  // Register and bus state
  // ----------------------------------------
  logic [2:0]        ctrl_reg, ctrl_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next, prev_reg, prev_next;
  op_t               op_reg, op_next;
  logic              aw_rdy_reg, aw_rdy_next, b_vld_reg, b_vld_next;
  logic [1:0]        b_resp_reg, b_resp_next, r_resp_reg, r_resp_next;
  logic              ar_rdy_reg, ar_rdy_next, r_vld_reg, r_vld_next;
  logic [31:0]       r_data_reg, r_data_next;
  logic              tog_reg, tog_next, es_tog_reg, es_tog_next, first_reg, first_next;
  state_t            state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next, elev_cnt_reg, elev_cnt_next;
  logic              rst_n_reg, rst_n_next, elev_reg, elev_next;
  logic              ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic              dq_oe_reg, dq_oe_next;
  logic [ADDR_W-1:0] pin_addr_reg, pin_addr_next;
  logic              elev_ok, busy, wr_go;

  assign busy    = (state_reg != ST_IDLE);
  assign elev_ok = !elev_reg || (elev_cnt_reg >= CNT_W'(RSP_CYC));

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_comb begin
    ctrl_next   = ctrl_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    op_next     = op_reg;
    aw_rdy_next = 1'b0;
    b_vld_next  = b_vld_reg && !S_AXI_BREADY_I;
    b_resp_next = b_resp_reg;
    ar_rdy_next = 1'b0;
    r_vld_next  = r_vld_reg && !S_AXI_RREADY_I;
    r_data_next = r_data_reg;
    r_resp_next = r_resp_reg;
    wr_go       = S_AXI_AWVALID_I && S_AXI_WVALID_I && !aw_rdy_reg && !b_vld_reg;
    if (busy && state_next == ST_IDLE) begin
      op_next = OP_NONE;
    end
    if (wr_go) begin
      aw_rdy_next = 1'b1;
      b_vld_next  = 1'b1;
      b_resp_next = RESP_OKAY;
      unique case (S_AXI_AWADDR_I)
        CTRL_OFS:  ctrl_next  = S_AXI_WDATA_I[2:0];
        CMD_OFS: begin
          if (!busy) begin
            op_next = op_t'(S_AXI_WDATA_I[2:0]);
          end
        end
        ADDR_OFS:  addr_next  = S_AXI_WDATA_I[ADDR_W-1:0];
        WDATA_OFS: wdata_next = S_AXI_WDATA_I[DATA_W-1:0];
        STATUS_OFS, RDATA_OFS: ;
        default:   b_resp_next = RESP_SLVERR;
      endcase
    end
    if (S_AXI_ARVALID_I && !ar_rdy_reg && !r_vld_reg) begin
      ar_rdy_next = 1'b1;
      r_vld_next  = 1'b1;
      r_resp_next = RESP_OKAY;
      r_data_next = 32'h0;
      unique case (S_AXI_ARADDR_I)
        CTRL_OFS:   r_data_next[2:0] = ctrl_reg;
        CMD_OFS:    r_data_next[2:0] = op_reg;
        ADDR_OFS:   r_data_next[ADDR_W-1:0] = addr_reg;
        WDATA_OFS:  r_data_next[DATA_W-1:0] = wdata_reg;
        STATUS_OFS: r_data_next[5:0] = {es_tog_reg, tog_reg, elev_ok, elev_reg, rb_s2_reg, busy};
        RDATA_OFS:  r_data_next[DATA_W-1:0] = rdata_reg;
        default:    r_resp_next = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      ctrl_reg   <= 3'h0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      op_reg     <= OP_NONE;
      aw_rdy_reg <= 1'b0;
      b_vld_reg  <= 1'b0;
      b_resp_reg <= RESP_OKAY;
      ar_rdy_reg <= 1'b0;
      r_vld_reg  <= 1'b0;
      r_data_reg <= 32'h0;
      r_resp_reg <= RESP_OKAY;
    end else begin
      ctrl_reg   <= ctrl_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      op_reg     <= op_next;
      aw_rdy_reg <= aw_rdy_next;
      b_vld_reg  <= b_vld_next;
      b_resp_reg <= b_resp_next;
      ar_rdy_reg <= ar_rdy_next;
      r_vld_reg  <= r_vld_next;
      r_data_reg <= r_data_next;
      r_resp_reg <= r_resp_next;
    end
  end

  // ----------------------------------------
  // Flash cycle sequencer
  // ----------------------------------------
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    rst_n_next    = rst_n_reg;
    ce_n_next     = ce_n_reg;
    oe_n_next     = oe_n_reg;
    we_n_next     = we_n_reg;
    dq_oe_next    = dq_oe_reg;
    pin_addr_next = pin_addr_reg;
    rdata_next    = rdata_reg;
    prev_next     = prev_reg;
    tog_next      = tog_reg;
    es_tog_next   = es_tog_reg;
    first_next    = first_reg;
    elev_next     = elev_reg;
    elev_cnt_next = elev_cnt_reg;
    // Elevated reset timing: counts ready time since raise or since busy last ended
    if (!elev_reg || !rb_s2_reg) begin
      elev_cnt_next = '0;
    end else if (elev_cnt_reg != '1) begin
      elev_cnt_next = elev_cnt_reg + 1'b1;
    end
    if (ctrl_reg[CTRL_ELEV_BIT] && !elev_reg) begin
      elev_next = 1'b1;
    end else if (!ctrl_reg[CTRL_ELEV_BIT] && elev_reg && !busy
                 && rb_s2_reg && elev_cnt_reg >= CNT_W'(RRB_CYC)) begin
      elev_next = 1'b0;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (op_reg != OP_NONE) begin
          state_next = ST_PENDING;
        end
      end
      ST_PENDING: begin
        cnt_next = '0;
        unique case (op_reg)
          OP_RESET: begin
            rst_n_next = 1'b0;
            state_next = ST_RST_LOW;
          end
          OP_READ, OP_POLL: begin
            first_next    = 1'b1;
            tog_next      = 1'b0;
            es_tog_next   = 1'b0;
            ce_n_next     = 1'b0;
            oe_n_next     = 1'b0;
            pin_addr_next = addr_reg;
            state_next    = ST_RD_ACT;
          end
          OP_WRITE, OP_PROTECT, OP_UNPROTECT: begin
            pin_addr_next = addr_reg;
            if (op_reg != OP_WRITE) begin
              pin_addr_next[ADDR_SIX_BIT]  = (op_reg == OP_UNPROTECT);
              pin_addr_next[ADDR_ONE_BIT]  = 1'b1;
              pin_addr_next[ADDR_ZERO_BIT] = 1'b0;
            end
            ce_n_next  = 1'b0;
            we_n_next  = 1'b0;
            dq_oe_next = 1'b1;
            state_next = ST_WR_ACT;
          end
          default: state_next = ST_IDLE;
        endcase
        if (!elev_ok && (op_reg == OP_WRITE || op_reg == OP_PROTECT
                         || op_reg == OP_UNPROTECT)) begin
          state_next    = ST_PENDING;
          ce_n_next     = 1'b1;
          we_n_next     = 1'b1;
          dq_oe_next    = 1'b0;
          pin_addr_next = pin_addr_reg;
        end
      end
      ST_RST_LOW: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(RP_CYC - 1)) begin
          rst_n_next = 1'b1;
          cnt_next   = '0;
          state_next = ST_RST_REC;
        end
      end
      ST_RST_REC: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(RH_CYC - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_RD_ACT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(ACC_CYC - 1)) begin
          rdata_next = dq_s2_reg;
          prev_next  = dq_s2_reg;
          first_next = 1'b0;
          cnt_next   = '0;
          oe_n_next  = 1'b1;
          ce_n_next  = 1'b1;
          state_next = ST_IDLE;
          if (op_reg == OP_POLL) begin
            ce_n_next  = ctrl_reg[CTRL_CETOG_BIT];
            state_next = ST_RD_GAP;
            if (!first_reg) begin
              tog_next    = tog_reg | (dq_s2_reg[TOGGLE_BIT] != prev_reg[TOGGLE_BIT]);
              es_tog_next = es_tog_reg
                            | (dq_s2_reg[ES_TOGGLE_BIT] != prev_reg[ES_TOGGLE_BIT]);
              if (dq_s2_reg[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]) begin
                ce_n_next  = 1'b1;
                state_next = ST_IDLE;
              end
            end
          end
        end
      end
      ST_RD_GAP: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(OEPH_CYC - 1)) begin
          cnt_next   = '0;
          oe_n_next  = 1'b0;
          ce_n_next  = 1'b0;
          state_next = ST_RD_ACT;
        end
      end
      ST_WR_ACT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(WP_CYC - 1)) begin
          cnt_next   = '0;
          we_n_next  = 1'b1;
          state_next = ST_WR_GAP;
        end
      end
      ST_WR_GAP: begin
        cnt_next   = cnt_reg + 1'b1;
        ce_n_next  = 1'b1;
        dq_oe_next = 1'b0;
        if (cnt_reg == CNT_W'(WPH_CYC - 1)) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= '0;
      rst_n_reg    <= 1'b1;
      ce_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      we_n_reg     <= 1'b1;
      dq_oe_reg    <= 1'b0;
      pin_addr_reg <= '0;
      rdata_reg    <= '0;
      prev_reg     <= '0;
      tog_reg      <= 1'b0;
      es_tog_reg   <= 1'b0;
      first_reg    <= 1'b0;
      elev_reg     <= 1'b0;
      elev_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      rst_n_reg    <= rst_n_next;
      ce_n_reg     <= ce_n_next;
      oe_n_reg     <= oe_n_next;
      we_n_reg     <= we_n_next;
      dq_oe_reg    <= dq_oe_next;
      pin_addr_reg <= pin_addr_next;
      rdata_reg    <= rdata_next;
      prev_reg     <= prev_next;
      tog_reg      <= tog_next;
      es_tog_reg   <= es_tog_next;
      first_reg    <= first_next;
      elev_reg     <= elev_next;
      elev_cnt_reg <= elev_cnt_next;
    end
  end

  assign S_AXI_AWREADY_O      = aw_rdy_reg;
  assign S_AXI_WREADY_O       = aw_rdy_reg;
  assign S_AXI_BVALID_O       = b_vld_reg;
  assign S_AXI_BRESP_O        = b_resp_reg;
  assign S_AXI_ARREADY_O      = ar_rdy_reg;
  assign S_AXI_RVALID_O       = r_vld_reg;
  assign S_AXI_RDATA_O        = r_data_reg;
  assign S_AXI_RRESP_O        = r_resp_reg;
  assign FLASH_RESET_N_O      = rst_n_reg;
  assign FLASH_RESET_ELEV_O   = elev_reg;
  assign FLASH_CE_N_O         = ce_n_reg;
  assign FLASH_OE_N_O         = oe_n_reg;
  assign FLASH_WE_N_O         = we_n_reg;
  assign FLASH_WIDTH_SELECT_O = ctrl_reg[CTRL_WIDTH_BIT];
  assign FLASH_ADDR_O         = pin_addr_reg;
  assign FLASH_DQ_O           = wdata_reg;
  assign FLASH_DQ_OE_O        = dq_oe_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [CNT_W-1:0] oe_hi_cnt_reg;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || !oe_n_reg) oe_hi_cnt_reg <= '0;
    else if (oe_hi_cnt_reg != '1) oe_hi_cnt_reg <= oe_hi_cnt_reg + 1'b1;
  end

  property p_reset_recovery;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) $rose(rst_n_reg) |-> oe_n_reg [*2];
  endproperty
  a_reset_recovery: assert property (p_reset_recovery) else $error("Read too soon after reset");

  property p_poll_ce_cycle;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (state_reg == ST_RD_GAP && ctrl_reg[CTRL_CETOG_BIT]) |-> ce_n_reg && oe_n_reg;
  endproperty
  a_poll_ce_cycle: assert property (p_poll_ce_cycle) else $error("Chip enable not cycled");

  property p_oe_gap;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $fell(oe_n_reg) |-> oe_hi_cnt_reg >= CNT_W'(OEPH_CYC);
  endproperty
  a_oe_gap: assert property (p_oe_gap) else $error("Output enable gap too short");

  property p_protect_addr;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ($fell(we_n_reg) && op_reg == OP_PROTECT) |-> !FLASH_ADDR_O[ADDR_SIX_BIT]
        && FLASH_ADDR_O[ADDR_ONE_BIT] && !FLASH_ADDR_O[ADDR_ZERO_BIT];
  endproperty
  a_protect_addr: assert property (p_protect_addr) else $error("Bad protect address");

  property p_unprotect_addr;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ($fell(we_n_reg) && op_reg == OP_UNPROTECT) |-> FLASH_ADDR_O[ADDR_SIX_BIT]
        && FLASH_ADDR_O[ADDR_ONE_BIT] && !FLASH_ADDR_O[ADDR_ZERO_BIT];
  endproperty
  a_unprotect_addr: assert property (p_unprotect_addr) else $error("Bad unprotect address");

  property p_elev_setup;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ($fell(we_n_reg) && elev_reg) |-> $past(elev_cnt_reg) >= CNT_W'(RSP_CYC);
  endproperty
  a_elev_setup: assert property (p_elev_setup) else $error("Write before unprotect setup");

  property p_elev_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $fell(elev_reg) |-> $past(rb_s2_reg) && $past(elev_cnt_reg) >= CNT_W'(RRB_CYC);
  endproperty
  a_elev_hold: assert property (p_elev_hold) else $error("Unprotect level dropped early");
endmodule

// ### src/flash_host_pkg.sv
package flash_host_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RP_NS       = 500;
  localparam int T_RH_NS       = 50;
  localparam int T_OEPH_NS     = 20;
  localparam int T_RSP_NS      = 4000;
  localparam int T_RRB_NS      = 4000;
  localparam int T_ACC_NS      = 70;
  localparam int T_WP_NS       = 35;
  localparam int T_WPH_NS      = 30;
  localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC   = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEPH_CYC = (T_OEPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSP_CYC  = (T_RSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RRB_CYC  = (T_RRB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] ADDR_OFS   = 8'h08;
  localparam logic [7:0] WDATA_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RDATA_OFS  = 8'h14;
  localparam int CTRL_WIDTH_BIT = 0;
  localparam int CTRL_ELEV_BIT  = 1;
  localparam int CTRL_CETOG_BIT = 2;
  localparam int ADDR_SIX_BIT   = 6;
  localparam int ADDR_ONE_BIT   = 1;
  localparam int ADDR_ZERO_BIT  = 0;
  localparam int TOGGLE_BIT     = 6;
  localparam int ES_TOGGLE_BIT  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_READ      = 3'h1,
    OP_WRITE     = 3'h2,
    OP_RESET     = 3'h3,
    OP_POLL      = 3'h4,
    OP_PROTECT   = 3'h5,
    OP_UNPROTECT = 3'h6
  } op_t;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_RST_LOW = 8'h02,
    ST_RST_REC = 8'h04,
    ST_RD_ACT  = 8'h08,
    ST_RD_GAP  = 8'h10,
    ST_WR_ACT  = 8'h20,
    ST_WR_GAP  = 8'h40,
    ST_PENDING = 8'h80
  } state_t;
endpackage

// ### tb/flash_model.sv
`timescale 1ns/10ps
module flash_model #(
  parameter int         PROG_NS  = 4000,
  parameter int         STBY_NS  = 20000,
  parameter logic [5:0] SUSP_SEC = 6'h03
) (
  input  wire logic        reset_n_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  output logic             ready_busy_n_o
);
  logic [21:0] wa = '0;
  logic [15:0] wd = '0;
  logic        tog = 1'b0;
  logic        es = 1'b0;
  logic        stby = 1'b0;
  int          gen = 0;
  logic        drv = 1'b0;
  initial dq_o = 16'h0000;
  initial ready_busy_n_o = 1'b1;
  // ----------------------------------------
  // Embedded program and reset
  // ----------------------------------------
  task automatic run_busy(input int g);
    #40 if (g == gen) ready_busy_n_o = 1'b0;
    #(PROG_NS - 40) if (g == gen) ready_busy_n_o = 1'b1;
  endtask
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i) begin
    wa = addr_i;
    wd = dq_i;
    gen++;
    fork run_busy(gen); join_none
  end
  always @(negedge reset_n_i) begin
    gen++;
    fork
      begin #1000 ready_busy_n_o = 1'b1; end
      begin #(STBY_NS) if (!reset_n_i) stby = 1'b1; end
    join_none
  end
  always @(posedge reset_n_i) stby = 1'b0;
  // ----------------------------------------
  // Read and status answers
  // ----------------------------------------
  always @(negedge oe_n_i or negedge ce_n_i) if (!oe_n_i && !ce_n_i) begin
    logic [15:0] v;
    if (stby || !reset_n_i) v = ~dq_o;
    else if (!ready_busy_n_o && addr_i[21:20] == wa[21:20]) begin
      tog = ~tog;
      v = {wd[15:8], ~wd[7], tog, wd[5:0]};
    end else if (addr_i[21:16] == SUSP_SEC) begin
      es = ~es;
      v = {13'h0000, es, 2'h0};
    end else v = (addr_i == wa) ? wd : addr_i[15:0] ^ 16'h5a5a;
    #70 dq_o = v;
    drv = 1'b1;
  end
  // Released bus shows inverse once per read
  always @(posedge oe_n_i or posedge ce_n_i) if (drv) begin
    drv = 1'b0;
    dq_o = ~dq_o;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb
  import flash_host_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wdt = '0, v;
  logic [1:0] r;
  logic awr, wr_r, bv, arr, rv, rst_fo, elev, ce_n, oe_n, we_n, wsel, dq_oe, rdy;
  logic [1:0] brs, rrs;
  logic [31:0] rdt;
  logic [21:0] fa, we_addr = '0;
  logic [15:0] dq_h, dq_m;
  wire [15:0] dq_bus = dq_oe ? dq_h : dq_m;
  logic ce_q = 1'b1, we_q = 1'b1, elev_q = 1'b0;
  int n_mismatch = 0, num_checks = 0, ce_rises = 0, rst_run = 0, last_rst = 0;
  int rdy_cnt = 0, elev_wes = 0, n;
  initial forever #25 clk = ~clk;
  flash_host flash_host_inst (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdt), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdt),
    .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .FLASH_RESET_N_O(rst_fo),
    .FLASH_RESET_ELEV_O(elev), .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
    .FLASH_WIDTH_SELECT_O(wsel), .FLASH_ADDR_O(fa), .FLASH_DQ_I(dq_bus), .FLASH_DQ_O(dq_h),
    .FLASH_DQ_OE_O(dq_oe), .FLASH_READY_BUSY_N_I(rdy));
  flash_model flash_model_inst (.reset_n_i(rst_fo), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(fa), .dq_i(dq_bus), .dq_o(dq_m), .ready_busy_n_o(rdy));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
    @(posedge clk);
    awa <= a; wdt <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) begin s = brs; bry <= 1'b0; break; end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) begin d = rdt; s = rrs; rry <= 1'b0; break; end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    axi_rd(a, d, r);
    chk("rresp", {30'h0, RESP_OKAY}, r);
  endtask
  task automatic op(input op_t o, input logic [31:0] a);
    int k;
    wr(ADDR_OFS, a);
    wr(CMD_OFS, {29'h0, o});
    k = 0;
    do begin rd(STATUS_OFS, v); k++; end while (v[0] !== 1'b0 && k < 500);
    chk("idle", 0, v[0]);
  endtask
  // ----------------------------------------
  // Pin monitor
  // ----------------------------------------
  always @(posedge clk) begin
    ce_q <= ce_n;
    we_q <= we_n;
    elev_q <= elev;
    if (ce_n && !ce_q) ce_rises <= ce_rises + 1;
    if (!we_n) we_addr <= fa;
    rst_run <= rst_fo ? 0 : rst_run + 1;
    if (rst_fo && rst_run != 0) last_rst <= rst_run;
    rdy_cnt <= (elev && rdy) ? rdy_cnt + 1 : 0;
    if (elev && !we_n && we_q) begin
      elev_wes <= elev_wes + 1;
      chk("elev_setup", 1, rdy_cnt >= RSP_CYC);
    end
    if (elev_q && !elev) chk("elev_hold", 1, rdy_cnt >= RRB_CYC);
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("pins_rst", 32'h1e, {elev, rst_fo, ce_n, oe_n, we_n, dq_oe});
    rd(CTRL_OFS, v); chk("ctrl_rst", 0, v);
    axi_wr(8'h18, 32'h1, r); chk("bresp_bad", {30'h0, RESP_SLVERR}, r);
    axi_rd(8'h1c, v, r); chk("rresp_bad", {30'h0, RESP_SLVERR}, r); chk("rdata_bad", 0, v);
    wr(CTRL_OFS, 32'h1); rd(CTRL_OFS, v); chk("ctrl", 1, v); chk("wsel", 1, wsel);
    wr(CTRL_OFS, 32'h0);
    op(OP_READ, 32'h012345); rd(RDATA_OFS, v); chk("rd_arr", 32'h2345 ^ 32'h5a5a, v);
    wr(WDATA_OFS, 32'h00b7); op(OP_WRITE, 32'h010040);
    op(OP_READ, 32'h300011); rd(RDATA_OFS, v); chk("rd_bank", 32'h0011 ^ 32'h5a5a, v);
    op(OP_READ, 32'h010040); rd(RDATA_OFS, v); chk("poll_bit", 0, v[7]);
    n = ce_rises; op(OP_POLL, 32'h010040); rd(STATUS_OFS, v);
    chk("tog_seen", 1, v[4]);
    chk("es_quiet", 0, v[5]);
    chk("ce_once", 1, ce_rises - n);
    op(OP_READ, 32'h010040); rd(RDATA_OFS, v); chk("true_data", 32'h00b7, v);
    wr(CTRL_OFS, 32'h4); n = ce_rises; op(OP_POLL, 32'h030000); rd(STATUS_OFS, v);
    chk("es_seen", 1, v[5]);
    chk("ce_cycled", 1, (ce_rises - n) >= 2);
    wr(CTRL_OFS, 32'h0);
    op(OP_WRITE, 32'h010050); op(OP_RESET, 32'h0);
    chk("rst_width", RP_CYC, last_rst);
    // Well before the aborted program would have ended on its own
    repeat (15) @(posedge clk);
    rd(STATUS_OFS, v); chk("ready_abort", 1, v[1]);
    op(OP_READ, 32'h000077); rd(RDATA_OFS, v); chk("rd_rst", 32'h0077 ^ 32'h5a5a, v);
    op(OP_PROTECT, 32'h3fffff); chk("prot", 32'h02, we_addr & 22'h43);
    op(OP_UNPROTECT, 32'h0); chk("unprot", 32'h42, we_addr & 22'h43);
    wr(CTRL_OFS, 32'h2); op(OP_WRITE, 32'h010060); chk("elev_wr", 1, elev_wes != 0);
    wr(CTRL_OFS, 32'h0);
    n = 0;
    while (elev !== 1'b0 && n < 600) begin @(posedge clk); n++; end
    chk("elev_drop", 0, elev);
    finish_test();
  end
endmodule
